// File: logic/diag_bank_pkg.sv
// Parameter map, field layout and limits of the diagnostic bank
package diag_bank_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_FORCE_MATRIX = 16'h050C;
	localparam logic [ADDR_W-1:0] OFS_INPUT_STATE_FORCE = 16'h050E;
	localparam logic [ADDR_W-1:0] OFS_KEYPAD_KEY_STATE = 16'h0510;
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_STATE = 16'h0512;
	localparam logic [ADDR_W-1:0] OFS_FAULT_LOG_CLEAR = 16'h0514;
	localparam logic [ADDR_W-1:0] OFS_ANALOG1_DEAD_BAND = 16'h0528;
	localparam logic [ADDR_W-1:0] OFS_ANALOG2_DEAD_BAND = 16'h052A;
	localparam logic [ADDR_W-1:0] OFS_ANALOG1_ZERO_SHIFT = 16'h052C;
	localparam logic [ADDR_W-1:0] OFS_ANALOG2_ZERO_SHIFT = 16'h052E;
	localparam logic [ADDR_W-1:0] OFS_INPUT_FORCE_PERMIT_MASK = 16'h040C;
	localparam logic [ADDR_W-1:0] OFS_LATEST_ERROR_CODE = 16'h0500;
	localparam logic [ADDR_W-1:0] OFS_ERROR_SLOT_STEP = 16'h0002;
	localparam int NUM_INPUTS = 8;
	localparam int NUM_OUTPUTS = 6;
	localparam int NUM_SW_FN = 8;
	localparam int NUM_KEYS = 5;
	localparam int NUM_SLOTS = 5;
	localparam int FN_SEL_W = 4;
	localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
	localparam logic [DATA_W-1:0] CLEAR_VALUE = 16'h0000;
	localparam logic signed [DATA_W-1:0] BAND_MAX_MV = 16'sd10000;
	localparam logic signed [DATA_W-1:0] SHIFT_MIN_MV = -16'sd10000;
	localparam logic signed [DATA_W-1:0] SHIFT_MAX_MV = 16'sd10000;
	typedef enum logic [1:0] {MODE_PULSE, MODE_SEQUENCE, MODE_VELOCITY, MODE_TORQUE} drive_mode_e;
endpackage : diag_bank_pkg

// File: logic/drive_diag_io_force_bank.sv
// Diagnostic parameter bank: I/O state, forcing, error history, analog conditioning
// Behaviour
// RULE1 - Force matrix bit n drives outputs assigned to software function n active.
// RULE2 - Input state read returns live input levels, bit 0 is input one. The code returns digital_in_eff, so forced inputs read as their forced values.
// RULE3 - Input state write forces each permitted input to its written bit.
// RULE4 - Permit mask has one bit per input; 1 allows forcing.
// RULE5 - Keypad register is read-only; 1 pressed, five keys in bits 0..4.
// RULE6 - Output state register is read-only, bits 0..5 show outputs one..six.
// RULE7 - Writing 0 to history clear erases every stored error code.
// RULE8 - Newest error code in first slot, older codes shift through four more.
// RULE9 - Analog magnitude below its dead band yields no analog command.
// RULE10 - Velocity mode adds analog one offset, limited to plus/minus 10000 mV.
// RULE11 - Torque mode adds analog two offset, limited to plus/minus 10000 mV.
// RULE12 - Forced values replace live values until rewritten or reset.
`timescale 1ns/100ps
module drive_diag_io_force_bank
	import diag_bank_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_ack,
	output logic reg_err,
	input wire logic [NUM_INPUTS-1:0] digital_in,
	input wire logic [NUM_KEYS-1:0] keypad_keys,
	input wire logic [NUM_OUTPUTS-1:0] output_fn_level,
	input wire logic [NUM_OUTPUTS*FN_SEL_W-1:0] output_fn_sel,
	input wire logic [NUM_OUTPUTS-1:0] output_is_sw_fn,
	input wire logic error_event,
	input wire logic [DATA_W-1:0] error_code,
	input wire logic [1:0] drive_mode,
	input wire logic signed [DATA_W-1:0] analog1_mv,
	input wire logic signed [DATA_W-1:0] analog2_mv,
	output logic [NUM_INPUTS-1:0] digital_in_eff,
	output logic [NUM_OUTPUTS-1:0] digital_out,
	output logic signed [DATA_W-1:0] analog1_cmd,
	output logic signed [DATA_W-1:0] analog2_cmd
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [NUM_SW_FN-1:0] output_force_matrix_reg;
	logic [NUM_INPUTS-1:0] input_force_permit_mask_reg;
	logic [NUM_INPUTS-1:0] forced_mask_reg;
	logic [NUM_INPUTS-1:0] forced_value_reg;
	logic [DATA_W-1:0] error_slot_reg [NUM_SLOTS];
	logic signed [DATA_W-1:0] analog1_dead_band_reg;
	logic signed [DATA_W-1:0] analog2_dead_band_reg;
	logic signed [DATA_W-1:0] analog1_zero_shift_reg;
	logic signed [DATA_W-1:0] analog2_zero_shift_reg;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire hit_fot = reg_addr == OFS_OUTPUT_FORCE_MATRIX;
	wire hit_its = reg_addr == OFS_INPUT_STATE_FORCE;
	wire hit_key = reg_addr == OFS_KEYPAD_KEY_STATE;
	wire hit_ost = reg_addr == OFS_OUTPUT_STATE;
	wire hit_clr = reg_addr == OFS_FAULT_LOG_CLEAR;
	wire hit_db1 = reg_addr == OFS_ANALOG1_DEAD_BAND;
	wire hit_db2 = reg_addr == OFS_ANALOG2_DEAD_BAND;
	wire hit_of1 = reg_addr == OFS_ANALOG1_ZERO_SHIFT;
	wire hit_of2 = reg_addr == OFS_ANALOG2_ZERO_SHIFT;
	wire hit_prm = reg_addr == OFS_INPUT_FORCE_PERMIT_MASK;
	logic [NUM_SLOTS-1:0] hit_slot;
	logic [DATA_W-1:0] slot_rdata;
	always_comb
	begin
		slot_rdata = RESET_VALUE;
		for (int i = 0; i < NUM_SLOTS; i++)
		begin
			hit_slot[i] = reg_addr == OFS_LATEST_ERROR_CODE + ADDR_W'(i) * OFS_ERROR_SLOT_STEP;
			if (hit_slot[i])
				slot_rdata = error_slot_reg[i];
		end
	end
	// Slot 0 accepts the clear value too; the other slots refuse writes
	wire clear_req = reg_wr && reg_wdata == CLEAR_VALUE && (hit_clr || hit_slot[0]); // RULE7
	wire ro_hit = hit_key || hit_ost || (|hit_slot[NUM_SLOTS-1:1]);
	wire rw_hit = hit_fot || hit_its || hit_db1 || hit_db2 || hit_of1 || hit_of2 || hit_prm;
	wire rd_ok = reg_rd && (rw_hit || ro_hit || hit_clr || hit_slot[0]);
	wire wr_fot = reg_wr && hit_fot;
	wire wr_its = reg_wr && hit_its;
	wire wr_prm = reg_wr && hit_prm;
	// Out-of-range analog settings are refused rather than clipped
	wire band_ok = !reg_wdata[DATA_W-1] && $signed(reg_wdata) <= BAND_MAX_MV;
	wire shift_ok = $signed(reg_wdata) >= SHIFT_MIN_MV && $signed(reg_wdata) <= SHIFT_MAX_MV;
	wire wr_db1 = reg_wr && hit_db1 && band_ok;
	wire wr_db2 = reg_wr && hit_db2 && band_ok;
	wire wr_of1 = reg_wr && hit_of1 && shift_ok;
	wire wr_of2 = reg_wr && hit_of2 && shift_ok;
	wire bad_write = reg_wr && ((hit_db1 || hit_db2) && !band_ok || (hit_of1 || hit_of2) && !shift_ok);
	// A refused analog write answers with an error only, never with an acknowledge as well
	wire wr_ok = reg_wr && (rw_hit && !bad_write || clear_req);

	// ----------------------------------------
	// Input forcing
	// ----------------------------------------
	wire [NUM_INPUTS-1:0] write_permit = input_force_permit_mask_reg; // RULE4
	wire [NUM_INPUTS-1:0] forced_mask_next = wr_its ? (forced_mask_reg | write_permit) : forced_mask_reg;
	wire [NUM_INPUTS-1:0] forced_value_next = wr_its
		? ((forced_value_reg & ~write_permit) | (reg_wdata[NUM_INPUTS-1:0] & write_permit))
		: forced_value_reg; // RULE3
	wire [NUM_INPUTS-1:0] digital_in_next = (digital_in & ~forced_mask_reg)
		| (forced_value_reg & forced_mask_reg); // RULE12

	// ----------------------------------------
	// Output function map
	// ----------------------------------------
	logic [NUM_OUTPUTS-1:0] digital_out_next;
	always_comb
	begin
		for (int o = 0; o < NUM_OUTPUTS; o++)
		begin
			logic [FN_SEL_W-1:0] sel;
			sel = output_fn_sel[o*FN_SEL_W +: FN_SEL_W];
			if (output_is_sw_fn[o] && sel < FN_SEL_W'(NUM_SW_FN))
				digital_out_next[o] = output_force_matrix_reg[sel[2:0]]; // RULE1
			else
				digital_out_next[o] = output_fn_level[o];
		end
	end

	// ----------------------------------------
	// Analog conditioning
	// ----------------------------------------
	wire v_mode = drive_mode == 2'(MODE_VELOCITY);
	wire t_mode = drive_mode == 2'(MODE_TORQUE);
	wire signed [DATA_W:0] a1_shift = analog1_mv + (v_mode ? analog1_zero_shift_reg : 16'sh0000); // RULE10
	wire signed [DATA_W:0] a2_shift = analog2_mv + (t_mode ? analog2_zero_shift_reg : 16'sh0000); // RULE11
	wire [DATA_W:0] a1_abs = a1_shift[DATA_W] ? (DATA_W+1)'(-a1_shift) : a1_shift;
	wire [DATA_W:0] a2_abs = a2_shift[DATA_W] ? (DATA_W+1)'(-a2_shift) : a2_shift;
	// Sums are clamped to the 16-bit range before output
	function automatic logic signed [DATA_W-1:0] sat(input logic signed [DATA_W:0] v);
		if (v > 17'sh07FFF)
			return 16'sh7FFF;
		else if (v < -17'sh08000)
			return 16'sh8000;
		else
			return v[DATA_W-1:0];
	endfunction : sat
	wire signed [DATA_W-1:0] analog1_next = (a1_abs < {1'b0, analog1_dead_band_reg}) ? 16'sh0000 : sat(a1_shift); // RULE9
	wire signed [DATA_W-1:0] analog2_next = (a2_abs < {1'b0, analog2_dead_band_reg}) ? 16'sh0000 : sat(a2_shift); // RULE9

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [DATA_W-1:0] rdata_next;
	always_comb
	begin
		rdata_next = RESET_VALUE;
		if (hit_fot)
			rdata_next = DATA_W'(output_force_matrix_reg);
		else if (hit_its)
			rdata_next = DATA_W'(digital_in_eff); // RULE2
		else if (hit_key)
			rdata_next = DATA_W'(keypad_keys); // RULE5
		else if (hit_ost)
			rdata_next = DATA_W'(digital_out); // RULE6
		else if (hit_db1)
			rdata_next = analog1_dead_band_reg;
		else if (hit_db2)
			rdata_next = analog2_dead_band_reg;
		else if (hit_of1)
			rdata_next = analog1_zero_shift_reg;
		else if (hit_of2)
			rdata_next = analog2_zero_shift_reg;
		else if (hit_prm)
			rdata_next = DATA_W'(input_force_permit_mask_reg);
		else if (|hit_slot)
			rdata_next = slot_rdata;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			output_force_matrix_reg <= '0;
			input_force_permit_mask_reg <= '0;
			forced_mask_reg <= '0; // RULE12
			forced_value_reg <= '0;
			analog1_dead_band_reg <= RESET_VALUE;
			analog2_dead_band_reg <= RESET_VALUE;
			analog1_zero_shift_reg <= RESET_VALUE;
			analog2_zero_shift_reg <= RESET_VALUE;
		end
		else
		begin
			if (wr_fot)
				output_force_matrix_reg <= reg_wdata[NUM_SW_FN-1:0];
			if (wr_prm)
				input_force_permit_mask_reg <= reg_wdata[NUM_INPUTS-1:0]; // RULE4
			forced_mask_reg <= forced_mask_next;
			forced_value_reg <= forced_value_next;
			if (wr_db1)
				analog1_dead_band_reg <= reg_wdata;
			if (wr_db2)
				analog2_dead_band_reg <= reg_wdata;
			if (wr_of1)
				analog1_zero_shift_reg <= reg_wdata;
			if (wr_of2)
				analog2_zero_shift_reg <= reg_wdata;
		end
	end

	// A new error in the clear cycle is kept in slot 0: the clear still empties the older slots
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < NUM_SLOTS; i++)
				error_slot_reg[i] <= RESET_VALUE;
		end
		else if (error_event)
		begin
			error_slot_reg[0] <= error_code; // RULE8
			for (int i = 1; i < NUM_SLOTS; i++)
				error_slot_reg[i] <= clear_req ? RESET_VALUE : error_slot_reg[i-1]; // RULE8
		end
		else if (clear_req)
		begin
			for (int i = 0; i < NUM_SLOTS; i++)
				error_slot_reg[i] <= RESET_VALUE; // RULE7
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			reg_rdata <= RESET_VALUE;
			reg_ack <= 1'b0;
			reg_err <= 1'b0;
			digital_in_eff <= '0;
			digital_out <= '0;
			analog1_cmd <= RESET_VALUE;
			analog2_cmd <= RESET_VALUE;
		end
		else
		begin
			reg_rdata <= reg_rd ? rdata_next : RESET_VALUE;
			reg_ack <= wr_ok || rd_ok;
			reg_err <= (reg_wr && !wr_ok) || (reg_rd && !rd_ok) || bad_write;
			digital_in_eff <= digital_in_next;
			digital_out <= digital_out_next;
			analog1_cmd <= analog1_next;
			analog2_cmd <= analog2_next;
		end
	end
endmodule : drive_diag_io_force_bank

// File: testbench/diag_bank_sva.sv
// Port checker of the diagnostic bank
`timescale 1ns/100ps
module diag_bank_sva
	import diag_bank_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic reg_err,
	input wire logic [NUM_KEYS-1:0] keypad_keys,
	input wire logic [1:0] drive_mode,
	input wire logic signed [DATA_W-1:0] analog1_mv,
	input wire logic signed [DATA_W-1:0] analog2_mv,
	input wire logic [NUM_INPUTS-1:0] digital_in_eff,
	input wire logic [NUM_OUTPUTS-1:0] digital_out,
	input wire logic signed [DATA_W-1:0] analog1_cmd,
	input wire logic signed [DATA_W-1:0] analog2_cmd
);
	// ----------------
	// Checks
	// ----------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	wire key_hit = reg_addr == OFS_KEYPAD_KEY_STATE;
	wire out_hit = reg_addr == OFS_OUTPUT_STATE;
	wire clr_bad = reg_wr && reg_addr == OFS_FAULT_LOG_CLEAR && reg_wdata != 16'h0000;
	key_ro_a: assert property (reg_wr && key_hit |=> reg_err && !reg_ack)
		else $error("keypad write not refused");
	out_ro_a: assert property (reg_wr && out_hit |=> reg_err && !reg_ack)
		else $error("output state write not refused");
	clear_value_a: assert property (clr_bad |=> reg_err && !reg_ack)
		else $error("nonzero clear not refused");
	key_read_a: assert property (reg_rd && key_hit |=> reg_rdata == {11'h000, $past(keypad_keys)})
		else $error("keypad read mismatch");
	out_read_a: assert property (reg_rd && out_hit |=> reg_rdata == {10'h000, $past(digital_out)})
		else $error("output state read mismatch");
	// Outside its mode the command is the raw input or zero, never shifted
	an1_shift_a: assert property (drive_mode != MODE_VELOCITY |=>
		analog1_cmd == $past(analog1_mv) || analog1_cmd == 16'h0000) else $error("offset one misapplied");
	an2_shift_a: assert property (drive_mode != MODE_TORQUE |=>
		analog2_cmd == $past(analog2_mv) || analog2_cmd == 16'h0000) else $error("offset two misapplied");
	reset_state_a: assert property (disable iff (1'b0) reset |-> digital_out == 6'h00 &&
		digital_in_eff == 8'h00 && !reg_ack) else $error("state not cleared in reset");
	cover property (reg_wr && reg_addr == OFS_INPUT_STATE_FORCE);
	cover property (clr_bad);
	cover property (drive_mode == MODE_TORQUE && analog2_cmd != 16'h0000);
endmodule : diag_bank_sva
bind drive_diag_io_force_bank diag_bank_sva sva_i (.*);

// File: testbench/drive_diag_io_force_bank_tb_top.sv
// Self-checking bench of the diagnostic bank
`timescale 1ns/100ps
module drive_diag_io_force_bank_tb_top;
	import diag_bank_pkg::*;
	logic core_clk = 1'b0, reset = 1'b0, reg_wr, reg_rd, reg_ack, reg_err, error_event = 1'b0;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, rd, error_code = 16'h0000;
	logic [7:0] digital_in = 8'h00, digital_in_eff;
	logic [4:0] keypad_keys = 5'h00;
	logic [5:0] output_fn_level = 6'h00, output_is_sw_fn = 6'h00, digital_out;
	logic [23:0] output_fn_sel = 24'h743210;
	logic [1:0] drive_mode = 2'h0, resp;
	logic signed [15:0] analog1_mv = 16'h0000, analog2_mv = 16'h0000, analog1_cmd, analog2_cmd;
	int num_errors = 0, n_compared = 0;
	drive_diag_io_force_bank uut (.*);
	fieldbus_master partner (.*);
	// ----------------
	// Helpers
	// ----------------
	initial forever #2.5 core_clk = ~core_clk;
	task automatic chk(input logic [15:0] got, exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, d, input logic bad);
		partner.acc(1'b1, a, d, rd, resp);
		chk({14'h0000, resp}, bad ? 16'h0001 : 16'h0002);
	endtask : wr
	task automatic rdx(input logic [15:0] a, exp);
		partner.acc(1'b0, a, 16'h0000, rd, resp);
		chk(rd, exp);
	endtask : rdx
	task automatic settle;
		repeat (2) @(negedge core_clk);
	endtask : settle
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_access;
		keypad_keys = 5'h11;
		rdx(OFS_KEYPAD_KEY_STATE, 16'h0011);
		wr(OFS_KEYPAD_KEY_STATE, 16'h0001, 1'b1);
		wr(OFS_OUTPUT_STATE, 16'h0001, 1'b1);
		wr(16'h0600, 16'h0001, 1'b1);
		rdx(OFS_ANALOG1_DEAD_BAND, 16'h0000);
	endtask : t_access
	task automatic t_outputs;
		output_is_sw_fn = 6'h3F;
		wr(OFS_OUTPUT_FORCE_MATRIX, 16'h0085, 1'b0);
		settle();
		chk({10'h000, digital_out}, 16'h0025);
		rdx(OFS_OUTPUT_STATE, 16'h0025);
		output_is_sw_fn = 6'h00;
		output_fn_level = 6'h1A;
		settle();
		chk({10'h000, digital_out}, 16'h001A);
	endtask : t_outputs
	task automatic t_inputs;
		wr(OFS_INPUT_FORCE_PERMIT_MASK, 16'h0011, 1'b0);
		wr(OFS_INPUT_STATE_FORCE, 16'h00FF, 1'b0);
		settle();
		chk({8'h00, digital_in_eff}, 16'h0011);
		digital_in = 8'hFF;
		wr(OFS_INPUT_STATE_FORCE, 16'h0000, 1'b0);
		settle();
		chk({8'h00, digital_in_eff}, 16'h00EE);
		rdx(OFS_INPUT_STATE_FORCE, 16'h00EE);
		reset = 1'b1;
		settle();
		reset = 1'b0;
		settle();
		chk({8'h00, digital_in_eff}, 16'h00FF);
		rdx(OFS_INPUT_FORCE_PERMIT_MASK, 16'h0000);
	endtask : t_inputs
	task automatic t_history;
		for (int i = 1; i <= 6; i++)
		begin
			error_code = 16'(i);
			error_event = 1'b1;
			@(negedge core_clk);
		end
		error_event = 1'b0;
		for (int k = 0; k < 5; k++)
			rdx(OFS_LATEST_ERROR_CODE + 16'(2 * k), 16'(6 - k));
		wr(OFS_FAULT_LOG_CLEAR, 16'h0001, 1'b1);
		rdx(OFS_LATEST_ERROR_CODE, 16'h0006);
		wr(OFS_FAULT_LOG_CLEAR, 16'h0000, 1'b0);
		for (int k = 0; k < 5; k++)
			rdx(OFS_LATEST_ERROR_CODE + 16'(2 * k), 16'h0000);
		// New error in the clear cycle: the new code stays, older slots empty
		error_code = 16'h0007;
		error_event = 1'b1;
		wr(OFS_LATEST_ERROR_CODE, 16'h0000, 1'b0);
		error_event = 1'b0;
		rdx(OFS_LATEST_ERROR_CODE, 16'h0007);
		rdx(OFS_LATEST_ERROR_CODE + 16'h0002, 16'h0000);
	endtask : t_history
	task automatic t_analog;
		wr(OFS_ANALOG1_DEAD_BAND, 16'h0064, 1'b0);
		wr(OFS_ANALOG2_DEAD_BAND, 16'h2711, 1'b1);
		wr(OFS_ANALOG1_ZERO_SHIFT, 16'h0032, 1'b0);
		wr(OFS_ANALOG2_ZERO_SHIFT, 16'hFFEC, 1'b0);
		wr(OFS_ANALOG2_ZERO_SHIFT, 16'h2711, 1'b1);
		drive_mode = MODE_VELOCITY;
		analog1_mv = 16'h001E;
		analog2_mv = 16'h00C8;
		settle();
		chk(analog1_cmd, 16'h0000);
		chk(analog2_cmd, 16'h00C8);
		analog1_mv = 16'h003C;
		settle();
		chk(analog1_cmd, 16'h006E);
		drive_mode = MODE_TORQUE;
		settle();
		chk(analog1_cmd, 16'h0000);
		chk(analog2_cmd, 16'h00B4);
		analog1_mv = 16'hFF9C;
		analog2_mv = 16'hFF38;
		settle();
		chk(analog1_cmd, 16'hFF9C);
		chk(analog2_cmd, 16'hFF24);
	endtask : t_analog
	task automatic wrap_up;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	initial
	begin
		// Raise reset as an edge so the asynchronous clear really happens
		@(negedge core_clk);
		reset = 1'b1;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		t_access();
		t_outputs();
		t_inputs();
		t_history();
		t_analog();
		wrap_up();
	end
	initial
	begin
		repeat (5000) @(posedge core_clk);
		num_errors++;
		wrap_up();
	end
endmodule : drive_diag_io_force_bank_tb_top

// File: testbench/fieldbus_master.sv
// Fieldbus master model reaching the bank's parameters
`timescale 1ns/100ps
module fieldbus_master
	import diag_bank_pkg::*;
(
	input wire logic core_clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [ADDR_W-1:0] reg_addr,
	output logic [DATA_W-1:0] reg_wdata,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic reg_err
);
	// ----------------
	// Access
	// ----------------
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 34'h000000000;
	task automatic acc(input logic w, input logic [15:0] a, d, output logic [15:0] q,
		output logic [1:0] r);
		@(negedge core_clk);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		{reg_wr, reg_rd} = 2'h0;
		// Released lines carry the inverse so stale words cannot pass for live ones
		reg_addr = ~a;
		reg_wdata = ~d;
		q = reg_rdata;
		r = {reg_ack, reg_err};
	endtask : acc
endmodule : fieldbus_master
